// *** rtl/wd_control.sv ***
// Windowed watchdog control: registers, key sequence, reset request.
// Assumes watchdog clock ticks arrive as one-cycle pulses on clk.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module wd_control (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output var  logic [7:0] rd_data,
  // Device state
  input  wire logic       debug_active,
  input  wire logic       special_mode,
  // Watchdog clock ticks
  input  wire logic       internal_rc_tick,
  input  wire logic       crystal_osc_tick,
  input  wire logic       autonomous_tick,
  // Reset request
  output var  logic       system_reset_req
);

  wd_count_if link ();

  wd_counter u_counter (
    .clk  (clk),
    .srst (srst),
    .link (link)
  );

  // ==========================================================
  // Register state
  logic [2:0]         rate_field;
  logic               window_mode_bit;
  logic               debug_stop_bit;
  logic               once_used;
  logic               wd_clock_select_low;
  logic               wd_clock_select_high;
  logic [7:0]         factory_test_b;
  logic [2:0]         status_sticky;
  logic               aclk_half;
  logic               restart_q;
  wd_pkg::key_state_t key_state;

  // ==========================================================
  // Decode
  logic ctl_wr;
  logic svc_wr;
  logic sel_wr;
  logic enabled;
  logic override;
  logic eff_window;
  logic key_bad;
  logic win_bad;
  logic violation;
  logic svc_restart;
  logic ctl_restart;
  logic sel_change;
  logic wr_mask;
  logic [2:0] wr_rate;

  assign ctl_wr   = wr_en && (addr == wd_pkg::ADDR_CONTROL);
  assign svc_wr   = wr_en && (addr == wd_pkg::ADDR_SERVICE);
  assign sel_wr   = wr_en && (addr == wd_pkg::ADDR_CLKSEL);
  assign wr_mask  = wr_data[wd_pkg::BIT_MASK];
  assign wr_rate  = wr_data[wd_pkg::RATE_MSB:0];
  assign enabled  = (rate_field != 3'h0);
  assign override = enabled && debug_active && !debug_stop_bit &&
                    special_mode;
  assign eff_window = window_mode_bit && !override;

  // Disabled watchdog ignores service writes entirely
  assign key_bad = svc_wr && enabled && (wr_data != wd_pkg::KEY_FIRST) &&
                   (wr_data != wd_pkg::KEY_SECOND);
  assign win_bad = svc_wr && enabled && eff_window &&
                   !link.in_window;
  assign violation = key_bad || win_bad;
  assign svc_restart = svc_wr && enabled && !violation &&
                       (wr_data == wd_pkg::KEY_SECOND) &&
                       (key_state == wd_pkg::KEY_ARMED);

  assign ctl_restart = ctl_wr &&
    (special_mode ||
     (!wr_mask && !once_used &&
      ((wr_rate != 3'h0) || wr_data[wd_pkg::BIT_WINDOW])) ||
     (wr_data[wd_pkg::BIT_DBG_STOP] && !debug_stop_bit));
  assign sel_change = sel_wr &&
    ({wr_data[1], wr_data[0]} !=
     {wd_clock_select_high, wd_clock_select_low});

  // ==========================================================
  // Counter link
  always_comb begin
    if (override) begin
      link.period_exp = wd_pkg::EXP_MAX;
    end else if (wd_clock_select_high) begin
      link.period_exp = wd_pkg::EXP_HIGH[rate_field];
    end else begin
      link.period_exp = wd_pkg::EXP_LOW[rate_field];
    end
  end

  assign link.freeze  = !enabled || (debug_active && debug_stop_bit);
  assign link.restart = restart_q;

  // Tick is registered so the selection mux never glitches the counter
  always_ff @(posedge clk) begin
    if (srst) begin
      link.tick <= 1'b0;
    end else if (wd_clock_select_high) begin
      link.tick <= autonomous_tick && aclk_half;
    end else if (wd_clock_select_low) begin
      link.tick <= crystal_osc_tick;
    end else begin
      link.tick <= internal_rc_tick;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aclk_half <= 1'b0;
    end else if (autonomous_tick) begin
      aclk_half <= !aclk_half;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clk) begin
    if (srst) begin
      rate_field      <= wd_pkg::RATE_RESET;
      window_mode_bit <= wd_pkg::WINDOW_RESET;
      debug_stop_bit  <= wd_pkg::DBG_RESET;
      once_used       <= 1'b0;
    end else if (ctl_wr) begin
      if (special_mode) begin
        debug_stop_bit <= wr_data[wd_pkg::BIT_DBG_STOP];
      end else if (wr_data[wd_pkg::BIT_DBG_STOP]) begin
        debug_stop_bit <= 1'b1;
      end
      if (!wr_mask) begin
        if (special_mode) begin
          window_mode_bit <= wr_data[wd_pkg::BIT_WINDOW];
          rate_field      <= wr_rate;
        end else if (!once_used) begin
          once_used <= 1'b1;
          if (wr_data[wd_pkg::BIT_WINDOW]) begin
            window_mode_bit <= 1'b1;
          end
          if (wr_rate != 3'h0) begin
            rate_field <= wr_rate;
          end
        end
      end
    end
  end

  // ==========================================================
  // Clock select and factory test
  always_ff @(posedge clk) begin
    if (srst) begin
      {wd_clock_select_high, wd_clock_select_low} <= wd_pkg::CLKSEL_RESET;
    end else if (sel_wr) begin
      {wd_clock_select_high, wd_clock_select_low} <= wr_data[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      factory_test_b <= wd_pkg::TEST_RESET;
    end else if (wr_en && special_mode && (addr == wd_pkg::ADDR_TEST_B)) begin
      factory_test_b <= wr_data;
    end
  end

  // ==========================================================
  // Key sequence and reset request
  always_ff @(posedge clk) begin
    if (srst) begin
      key_state <= wd_pkg::KEY_IDLE;
    end else if (!enabled || violation || svc_restart || link.expired) begin
      key_state <= wd_pkg::KEY_IDLE;
    end else if (svc_wr && (wr_data == wd_pkg::KEY_FIRST)) begin
      key_state <= wd_pkg::KEY_ARMED;
    end else begin
      case (key_state)
        wd_pkg::KEY_IDLE:  key_state <= wd_pkg::KEY_IDLE;
        wd_pkg::KEY_ARMED: key_state <= wd_pkg::KEY_ARMED;
        default:           key_state <= wd_pkg::KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= svc_restart || ctl_restart || sel_change ||
                   violation || link.expired;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      system_reset_req <= 1'b0;
    end else begin
      system_reset_req <= violation || link.expired;
    end
  end

  // Cause flags: hardware set wins over a write-one clear
  always_ff @(posedge clk) begin
    if (srst) begin
      status_sticky <= 3'h0;
    end else begin
      if (wr_en && (addr == wd_pkg::ADDR_STATUS)) begin
        status_sticky <= status_sticky & ~wr_data[2:0];
      end
      if (link.expired) begin
        status_sticky[wd_pkg::BIT_ST_TIMEOUT] <= 1'b1;
      end
      if (key_bad) begin
        status_sticky[wd_pkg::BIT_ST_BADKEY] <= 1'b1;
      end
      if (win_bad) begin
        status_sticky[wd_pkg::BIT_ST_EARLY] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk) begin
    if (srst || !rd_en) begin
      rd_data <= 8'h00;
    end else begin
      case (addr)
        wd_pkg::ADDR_CONTROL: rd_data <= {window_mode_bit, debug_stop_bit,
                                          3'h0, rate_field};
        wd_pkg::ADDR_TEST_A:  rd_data <= 8'h00;
        wd_pkg::ADDR_TEST_B:  rd_data <= factory_test_b;
        wd_pkg::ADDR_SERVICE: rd_data <= 8'h00;
        wd_pkg::ADDR_CLKSEL:  rd_data <= {6'h00, wd_clock_select_high,
                                          wd_clock_select_low};
        wd_pkg::ADDR_STATUS:  rd_data <= {4'h0,
                                 (key_state == wd_pkg::KEY_ARMED),
                                 status_sticky[2:0]};
        default:              rd_data <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Checks
  property p_early_write;
    @(posedge clk) disable iff (srst)
      svc_wr && enabled && eff_window && !link.in_window
      |=> system_reset_req;
  endproperty
  a_early_write: assert property (p_early_write)
    else $error("Early service write did not reset");

  property p_bad_key;
    @(posedge clk) disable iff (srst)
      svc_wr && enabled && (wr_data != 8'h55) && (wr_data != 8'hAA)
      |=> system_reset_req;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("Bad key did not reset");

  property p_key_restart;
    @(posedge clk) disable iff (srst)
      svc_wr && enabled && (wr_data == 8'hAA) &&
      (key_state == wd_pkg::KEY_ARMED) && (!eff_window || link.in_window)
      |=> restart_q && !system_reset_req;
  endproperty
  a_key_restart: assert property (p_key_restart)
    else $error("Key pair did not restart period");

  property p_disabled;
    @(posedge clk) disable iff (srst)
      svc_wr && !enabled && !link.expired |=> !system_reset_req;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Disabled watchdog reacted to service write");

  property p_mask;
    @(posedge clk) disable iff (srst)
      ctl_wr && wr_mask |=> $stable(rate_field) && $stable(window_mode_bit)
                            && $stable(once_used);
  endproperty
  a_mask: assert property (p_mask)
    else $error("Masked write changed fields");

  property p_once;
    @(posedge clk) disable iff (srst)
      ctl_wr && !special_mode && once_used |=> $stable(rate_field);
  endproperty
  a_once: assert property (p_once)
    else $error("Second normal write changed rate");

  property p_timeout;
    @(posedge clk) disable iff (srst)
      link.expired |=> system_reset_req && restart_q;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Timeout did not reset");

  property p_override;
    @(posedge clk) disable iff (srst)
      override |-> (link.period_exp == wd_pkg::EXP_MAX) && !eff_window;
  endproperty
  a_override: assert property (p_override)
    else $error("Override period wrong");

  property p_read_zero;
    @(posedge clk) disable iff (srst)
      rd_en && (addr == wd_pkg::ADDR_SERVICE) |=> rd_data == 8'h00;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("Service register read nonzero");

endmodule // wd_control
`default_nettype wire

// *** rtl/wd_pkg.sv ***
// Constants for the windowed watchdog control block.
// Assumes a single 50 MHz bus clock and byte-wide register port.
`default_nettype none
package wd_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_TEST_A  = 8'h0D;
  localparam logic [7:0] ADDR_TEST_B  = 8'h0E;
  localparam logic [7:0] ADDR_SERVICE = 8'h0F;
  localparam logic [7:0] ADDR_CLKSEL  = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h11;

  // ==========================================================
  // Control field positions
  localparam int BIT_WINDOW   = 7;
  localparam int BIT_DBG_STOP = 6;
  localparam int BIT_MASK     = 5;
  localparam int RATE_MSB     = 2;

  // Status field positions
  localparam int BIT_ST_TIMEOUT = 0;
  localparam int BIT_ST_BADKEY  = 1;
  localparam int BIT_ST_EARLY   = 2;
  localparam int BIT_ST_ARMED   = 3;

  // ==========================================================
  // Reset values
  localparam logic [2:0] RATE_RESET   = 3'h0;
  localparam logic       WINDOW_RESET = 1'b0;
  localparam logic       DBG_RESET    = 1'b0;
  localparam logic [1:0] CLKSEL_RESET = 2'h0;
  localparam logic [7:0] TEST_RESET   = 8'h00;

  // ==========================================================
  // Service keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ==========================================================
  // Period exponents per rate code; entry 0 is unused (disabled)
  localparam logic [4:0] EXP_LOW  [8] = '{5'd0, 5'd14, 5'd16, 5'd18,
                                          5'd20, 5'd22, 5'd23, 5'd24};
  localparam logic [4:0] EXP_HIGH [8] = '{5'd0, 5'd7, 5'd9, 5'd11,
                                          5'd13, 5'd15, 5'd16, 5'd17};
  localparam logic [4:0] EXP_MAX  = 5'd24;
  localparam int         CNT_W    = 25;

  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_t;

endpackage
`default_nettype wire

// *** rtl/wd_count_if.sv ***
// Link between watchdog control and its period counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface wd_count_if;
  logic       tick;
  logic       restart;
  logic       freeze;
  logic [4:0] period_exp;
  logic       expired;
  logic       in_window;

  modport ctrl    (output tick, restart, freeze, period_exp,
                   input  expired, in_window);
  modport counter (input  tick, restart, freeze, period_exp,
                   output expired, in_window);
endinterface
`default_nettype wire

// *** rtl/wd_counter.sv ***
// Watchdog period counter with window flag.
// Assumes tick is a one-cycle pulse per watchdog clock period.
`timescale 1ns/100ps
`default_nettype none
module wd_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control link
  wd_count_if.counter link
);

  logic [wd_pkg::CNT_W-1:0] count;
  logic [wd_pkg::CNT_W-1:0] period;
  logic [wd_pkg::CNT_W-1:0] open_at;

  // ==========================================================
  // Period and window boundary
  always_comb begin
    period  = 25'h1 << link.period_exp;
    open_at = period - (period >> 2);
  end

  // At or past the end: dropping the override can shrink period below count
  assign link.expired   = link.tick && !link.freeze &&
                          (count >= period - 25'h1);
  assign link.in_window = (count >= open_at);

  // ==========================================================
  // Counter
  always_ff @(posedge clk) begin
    if (srst || link.restart) begin
      count <= '0;
    end else if (link.tick && !link.freeze) begin
      count <= link.expired ? '0 : count + 25'h1;
    end
  end

  property p_freeze;
    @(posedge clk) disable iff (srst)
      link.freeze && !link.restart |=> $stable(count);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Counter moved while frozen");

  property p_window_bound;
    @(posedge clk) disable iff (srst)
      !link.restart && link.tick && !link.freeze &&
      (count == open_at - 25'h1)
      |=> link.in_window || $changed(link.period_exp);
  endproperty
  a_window_bound: assert property (p_window_bound)
    else $error("Window did not open at three quarters");

endmodule // wd_counter
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the windowed watchdog control block.
// Assumes wd_control is the top with plain ports and a single clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic       clk;
  logic       srst;
  logic       wr_en;
  logic       rd_en;
  logic       debug_active;
  logic       special_mode;
  logic       internal_rc_tick;
  logic       crystal_osc_tick;
  logic       autonomous_tick;
  logic       system_reset_req;
  logic       rc_on;
  logic       auto_on;
  logic       osc_on;
  logic       rd_pend;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] e;
  logic [7:0] bad;
  logic [7:0] exp_q[$];
  int         n_errors;
  int         checked;
  int         n_rst;
  int         cyc;
  int         c;
  int         base;
  integer     seed;

  wd_control u_wd_control (
    .clk              (clk),
    .srst             (srst),
    .addr             (addr),
    .wr_data          (wr_data),
    .wr_en            (wr_en),
    .rd_en            (rd_en),
    .rd_data          (rd_data),
    .debug_active     (debug_active),
    .special_mode     (special_mode),
    .internal_rc_tick (internal_rc_tick),
    .crystal_osc_tick (crystal_osc_tick),
    .autonomous_tick  (autonomous_tick),
    .system_reset_req (system_reset_req)
  );

  // ==========================================================
  // Clock and tick sources
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Crystal ticks stay random so an unselected source cannot leak in unnoticed
  always @(posedge clk) begin
    autonomous_tick  <= auto_on;
    internal_rc_tick <= rc_on;
    crystal_osc_tick <= osc_on | 1'($random(seed));
  end

  // ==========================================================
  // Output watcher
  always @(posedge clk) begin
    cyc++;
    if (cyc > 50000) begin
      n_errors++;
      wrap_up();
    end else begin
      if (system_reset_req === 1'b1) n_rst++;
      if (rd_pend) begin
        e = exp_q.pop_front();
        `CHK("rd_data", e, rd_data)
      end
      rd_pend <= rd_en;
    end
  end

  // ==========================================================
  // Tasks
  task automatic wrap_up;
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back(x);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic nores(input int n);
    base = n_rst;
    repeat (n) @(posedge clk);
    `CHK("reset_count", base, n_rst)
  endtask

  // Cycles from return of the last task until the reset request shows
  task automatic rst_in(input int lo, input int hi);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (system_reset_req !== 1'b1 && c < hi + 2);
    `CHK("reset_delay_ok", 1'b1, 1'(c >= lo && c <= hi))
  endtask

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 77091;
    srst = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    debug_active = 1'b0;
    special_mode = 1'b0;
    rc_on = 1'b0;
    auto_on = 1'b0;
    osc_on = 1'b0;
    rd_pend = 1'b0;
    n_errors = 0;
    checked = 0;
    n_rst = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(wd_pkg::ADDR_CONTROL, 8'h00);
    rd(wd_pkg::ADDR_TEST_A, 8'h00);
    wr(wd_pkg::ADDR_TEST_B, 8'hC3);
    rd(wd_pkg::ADDR_TEST_B, 8'h00);
    wr(wd_pkg::ADDR_SERVICE, 8'h12);
    nores(20);
    rd(wd_pkg::ADDR_SERVICE, 8'h00);
    rd(8'h20, 8'h00);
    // Fast source: half the autonomous rate, 2^7 ticks is 256 cycles
    auto_on <= 1'b1;
    wr(wd_pkg::ADDR_CLKSEL, 8'h02);
    rd(wd_pkg::ADDR_CLKSEL, 8'h02);
    wr(wd_pkg::ADDR_CONTROL, 8'h21);
    rd(wd_pkg::ADDR_CONTROL, 8'h00);
    wr(wd_pkg::ADDR_CONTROL, 8'h01);
    rst_in(250, 262);
    rd(wd_pkg::ADDR_CONTROL, 8'h01);
    wr(wd_pkg::ADDR_CONTROL, 8'h83);
    rd(wd_pkg::ADDR_CONTROL, 8'h01);
    base = n_rst;
    for (int i = 0; i < 3; i++) begin
      repeat (150) @(posedge clk);
      wr(wd_pkg::ADDR_SERVICE, 8'h55);
      wr(wd_pkg::ADDR_SERVICE, 8'h55);
      wr(wd_pkg::ADDR_SERVICE, 8'hAA);
    end
    wr(wd_pkg::ADDR_SERVICE, 8'hAA);
    rd(wd_pkg::ADDR_SERVICE, 8'h00);
    `CHK("reset_count", base, n_rst)
    do bad = 8'($random(seed)); while (bad == 8'h55 || bad == 8'hAA);
    wr(wd_pkg::ADDR_SERVICE, bad);
    rst_in(1, 3);
    // Cause flags: timeout and bad key seen so far, clear timeout only
    rd(wd_pkg::ADDR_STATUS, 8'h03);
    wr(wd_pkg::ADDR_STATUS, 8'h01);
    rd(wd_pkg::ADDR_STATUS, 8'h02);
    // Debug-stop can still be set once the fields are locked
    wr(wd_pkg::ADDR_CONTROL, 8'h40);
    rd(wd_pkg::ADDR_CONTROL, 8'h41);
    debug_active <= 1'b1;
    nores(600);
    debug_active <= 1'b0;
    rst_in(230, 262);
    // Window servicing
    do_reset();
    wr(wd_pkg::ADDR_CLKSEL, 8'h02);
    wr(wd_pkg::ADDR_CONTROL, 8'h81);
    repeat (50) @(posedge clk);
    wr(wd_pkg::ADDR_SERVICE, 8'h55);
    rst_in(1, 3);
    rd(wd_pkg::ADDR_STATUS, 8'h04);
    repeat (208) @(posedge clk);
    base = n_rst;
    wr(wd_pkg::ADDR_SERVICE, 8'h55);
    wr(wd_pkg::ADDR_SERVICE, 8'h55);
    wr(wd_pkg::ADDR_SERVICE, 8'hAA);
    `CHK("reset_count", base, n_rst)
    wr(wd_pkg::ADDR_SERVICE, 8'h55);
    rst_in(1, 3);
    // Low select from the RC source, 2^14 ticks
    do_reset();
    auto_on <= 1'b0;
    rc_on <= 1'b1;
    wr(wd_pkg::ADDR_CONTROL, 8'h01);
    rst_in(16380, 16392);
    // Oscillator source: RC goes quiet, so only a working select can expire
    rc_on <= 1'b0;
    osc_on <= 1'b1;
    wr(wd_pkg::ADDR_CLKSEL, 8'h01);
    rst_in(16380, 16392);
    // Special mode with debug: longest period, window ignored
    do_reset();
    special_mode <= 1'b1;
    rc_on <= 1'b0;
    auto_on <= 1'b1;
    wr(wd_pkg::ADDR_CLKSEL, 8'h02);
    wr(wd_pkg::ADDR_CONTROL, 8'h81);
    debug_active <= 1'b1;
    wr(wd_pkg::ADDR_SERVICE, 8'h55);
    wr(wd_pkg::ADDR_SERVICE, 8'hAA);
    nores(600);
    wr(wd_pkg::ADDR_TEST_B, 8'h5A);
    rd(wd_pkg::ADDR_TEST_B, 8'h5A);
    wr(wd_pkg::ADDR_TEST_A, 8'hFF);
    rd(wd_pkg::ADDR_TEST_A, 8'h00);
    wr(wd_pkg::ADDR_CONTROL, 8'h03);
    rd(wd_pkg::ADDR_CONTROL, 8'h03);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
